// ### hw/tcac_core.sv
`timescale 1ns/1ns
// Operation
// [R1] BCD seconds to year counters advance once per 32768 crystal edges.
// [R2] Date rolls over at month end, leap February handled through year 2099.
// [R3] Hours run in 12-hour with AM/PM or 24-hour; 12-hour after reset.
// [R4] After first power-up conversions start by themselves and repeat continuously.
// [R5] Temperature register holds last result; reading it never touches conversions.
// [R6] One-shot setting is kept outside and reloaded at every power-up.
// [R7] Alarm source selects thermal, time, either or none; none after reset.
// [R8] Thermal flag sets at temp >= high limit, clears at temp <= low limit.
// [R9] Clock flag sets when weekday, hour and minute match the alarm register.
// [R10] Any access to clock or clock alarm registers clears the clock flag.
// [R11] Alarm pin active level chosen by a configuration bit.
// [R12] Open-drain divided clock output, enabled and divided by configuration.
// [R13] One clock-register bit halts the timekeeping oscillator.
// [R14] Thirty-two bytes of SRAM, no effect on clock or thermometer.
// [R15] Every register selected by its own 8-bit code; serial data MSB first. The core has a parallel 32-bit AHB-lite slave and no serial link.
// [R16] Temperatures are 9-bit two's complement, half-degree steps.
// [R17] In either mode the alarm is thermal flag OR clock flag.
// [R18] Halt bit change takes effect only when the bus transfer ends.
// [R19] External sensor delivers result with done pulse; comparators update then.
module tcac_core
	import tcac_pkg::*;
#(
	parameter int XTAL_DIV = XTAL_HZ
) (
	// clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    rstn_i,
	// ahb-lite slave
	input  wire logic                    hsel_i,
	input  wire logic [tcac_pkg::ADDR_W-1:0] haddr_i,
	input  wire logic [1:0]              htrans_i,
	input  wire logic                    hwrite_i,
	input  wire logic [2:0]              hsize_i,
	input  wire logic [31:0]             hwdata_i,
	input  wire logic                    hready_i,
	output logic      [31:0]             hrdata_o,
	output logic                         hreadyout_o,
	output logic                         hresp_o,
	// crystal and temperature sensor
	input  wire logic                    crystal_input_i,
	input  wire logic                    temp_done_i,
	input  wire logic [8:0]              temp_result_i,
	output logic                         conv_start_o,
	// nonvolatile one-shot setting
	input  wire logic                    nvm_one_shot_i,
	output logic                         cfg_one_shot_o,
	// open-drain pins and interrupt
	output logic                         alarm_output_o,
	output logic                         alarm_output_oe_o,
	output logic                         divided_clock_output_o,
	output logic                         divided_clock_output_oe_o,
	output logic                         irq_o
);
	import tcac_pkg::*;

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	logic [7:0]  idx;
	logic        acc;
	logic        dp_wr;
	logic [7:0]  dp_idx;
	logic        wr_cfg, wr_lo, wr_hi, wr_alm, wr_stat, wr_mask, wr_high, wr_low, wr_start;
	logic        clk_access;
	logic [31:0] rd_mux;

	assign idx         = haddr_i[IDX_LSB +: 8];
	assign acc         = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dp_wr  <= 1'b0;
			dp_idx <= 8'h00;
		end else begin
			dp_wr  <= acc && hwrite_i;
			dp_idx <= idx;
		end
	end

	// each register answers to its own command code
	assign wr_cfg     = dp_wr && (dp_idx == IDX_CFG); // [R15]
	assign wr_lo      = dp_wr && (dp_idx == IDX_CLK_LO);
	assign wr_hi      = dp_wr && (dp_idx == IDX_CLK_HI);
	assign wr_alm     = dp_wr && (dp_idx == IDX_ALARM);
	assign wr_stat    = dp_wr && (dp_idx == IDX_STAT);
	assign wr_mask    = dp_wr && (dp_idx == IDX_MASK);
	assign wr_high    = dp_wr && (dp_idx == IDX_HIGH);
	assign wr_low     = dp_wr && (dp_idx == IDX_LOW);
	assign wr_start   = dp_wr && (dp_idx == IDX_START);
	assign clk_access = acc && (idx == IDX_CLK_LO || idx == IDX_CLK_HI || idx == IDX_ALARM);

	// ----------------------------------------------------------------
	// crystal synchroniser and prescaler
	// ----------------------------------------------------------------
	logic        xtal_s1, xtal_s2, xtal_s3;
	logic        xtal_edge;
	logic [14:0] presc;
	logic        tick;
	logic        halt, halt_pend;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xtal_s1 <= 1'b0;
			xtal_s2 <= 1'b0;
			xtal_s3 <= 1'b0;
		end else begin
			xtal_s1 <= crystal_input_i;
			xtal_s2 <= xtal_s1;
			xtal_s3 <= xtal_s2;
		end
	end
	assign xtal_edge = xtal_s2 && !xtal_s3;

	// a halted oscillator also stops the divided clock output for osc_div 1 to 3; osc_div 0 passes the crystal
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			presc <= 15'h0000;
		end else if (xtal_edge && !halt) begin // [R13]
			presc <= (presc == 15'(XTAL_DIV - 1)) ? 15'h0000 : presc + 15'h0001; // [R1]
		end
	end
	assign tick = xtal_edge && !halt && (presc == 15'(XTAL_DIV - 1));

	// ----------------------------------------------------------------
	// halt bit, applied on an idle bus cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			halt      <= 1'b0;
			halt_pend <= 1'b0;
		end else begin
			if (wr_lo) begin
				halt_pend <= hwdata_i[HALT_BIT];
			end
			if (!acc && !dp_wr) begin
				halt <= halt_pend; // [R18]
			end
		end
	end

	// ----------------------------------------------------------------
	// calendar
	// ----------------------------------------------------------------
	tcac_time_t tm, next_tm;
	logic [7:0] month_end;
	logic [6:0] year_bin;
	logic       c_min, c_hour, c_day, c_month;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	assign year_bin = 7'({3'h0, tm.year[7:4]} * 7'd10) + {3'h0, tm.year[3:0]};

	always_comb begin
		case (tm.month)
			8'h02:   month_end = (year_bin[1:0] == 2'h0) ? 8'h29 : 8'h28; // [R2]
			8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30; // [R2]
			default: month_end = 8'h31;
		endcase
	end

	always_comb begin
		next_tm = tm;
		c_min   = (tm.sec == 8'h59);
		c_hour  = c_min && (tm.min == 8'h59);
		c_day   = 1'b0;
		next_tm.sec = c_min ? 8'h00 : bcd_inc(tm.sec);
		if (c_min) begin
			next_tm.min = (tm.min == 8'h59) ? 8'h00 : bcd_inc(tm.min);
		end
		if (c_hour) begin
			if (tm.mode12) begin // [R3]
				if (tm.hour[4:0] == 5'h12) begin
					next_tm.hour = {tm.hour[PM_BIT], 5'h01};
				end else if (tm.hour[4:0] == 5'h11) begin
					next_tm.hour = {!tm.hour[PM_BIT], 5'h12};
					c_day        = tm.hour[PM_BIT];
				end else begin
					next_tm.hour = {tm.hour[PM_BIT], 5'(bcd_inc({3'h0, tm.hour[4:0]}))};
				end
			end else if (tm.hour == 6'h23) begin
				next_tm.hour = 6'h00;
				c_day        = 1'b1;
			end else begin
				next_tm.hour = 6'(bcd_inc({2'h0, tm.hour}));
			end
		end
		c_month = c_day && (tm.date == month_end);
		if (c_day) begin
			next_tm.wday = (tm.wday == 8'h07) ? 8'h01 : bcd_inc(tm.wday);
			next_tm.date = c_month ? 8'h01 : bcd_inc(tm.date); // [R2]
		end
		if (c_month) begin
			next_tm.month = (tm.month == 8'h12) ? 8'h01 : bcd_inc(tm.month);
			if (tm.month == 8'h12) begin
				next_tm.year = (tm.year == 8'h99) ? 8'h00 : bcd_inc(tm.year);
			end
		end
	end

	// a software write wins over the tick in the same cycle
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tm <= TIME_RST; // [R3]
		end else if (wr_lo) begin
			tm.sec    <= {1'b0, hwdata_i[6:0]};
			tm.min    <= hwdata_i[15:8];
			tm.mode12 <= hwdata_i[22];
			tm.hour   <= hwdata_i[21:16];
			tm.wday   <= hwdata_i[31:24];
		end else if (wr_hi) begin
			tm.date  <= hwdata_i[7:0];
			tm.month <= hwdata_i[15:8];
			tm.year  <= hwdata_i[23:16];
		end else if (tick) begin
			tm <= next_tm; // [R1]
		end
	end

	// ----------------------------------------------------------------
	// configuration and conversion control
	// ----------------------------------------------------------------
	tcac_cfg_t  cfg;
	logic       init_done;
	logic       busy;
	logic       one_req;
	logic [8:0] temp, high_lim, low_lim;

	// the one-shot setting lives in external nonvolatile storage and is
	// reloaded right after reset release
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg       <= CFG_RST; // [R7]
			init_done <= 1'b0;
		end else if (!init_done) begin
			cfg.one_shot <= nvm_one_shot_i; // [R6]
			init_done    <= 1'b1;
		end else if (wr_cfg) begin
			cfg <= tcac_cfg_t'(hwdata_i[$bits(tcac_cfg_t)-1:0]);
		end
	end
	assign cfg_one_shot_o = cfg.one_shot;

	assign conv_start_o = init_done && !busy && (!cfg.one_shot || one_req); // [R4]

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy    <= 1'b0;
			one_req <= 1'b0;
		end else begin
			if (conv_start_o) begin
				busy <= 1'b1;
			end else if (temp_done_i) begin
				busy <= 1'b0;
			end
			if (wr_start) begin
				one_req <= 1'b1;
			end else if (conv_start_o) begin
				one_req <= 1'b0;
			end
		end
	end

	// only a finished conversion loads the result; reads have no side effect
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			temp     <= 9'h000;
			high_lim <= HIGH_RST;
			low_lim  <= LOW_RST;
		end else begin
			if (temp_done_i) begin
				temp <= temp_result_i; // [R5]
			end
			if (wr_high) begin
				high_lim <= hwdata_i[TEMP_PAD +: 9];
			end
			if (wr_low) begin
				low_lim <= hwdata_i[TEMP_PAD +: 9];
			end
		end
	end

	// ----------------------------------------------------------------
	// alarms
	// ----------------------------------------------------------------
	tcac_alarm_t alm;
	logic        thermal_alarm_flag, clock_alarm_flag;
	logic        t_hi, t_lo, t_match;
	logic        alarm_active, alarm_level;

	assign t_hi    = $signed(temp_result_i) >= $signed(high_lim); // [R16]
	assign t_lo    = $signed(temp_result_i) <= $signed(low_lim); // [R16]
	assign t_match = tick && (next_tm.sec == 8'h00) && (next_tm.wday == alm.wday) &&
	                 (next_tm.hour == alm.hour) && (next_tm.min == alm.min);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alm <= ALARM_RST;
		end else if (wr_alm) begin
			alm <= '{wday: hwdata_i[31:24], hour: hwdata_i[21:16], min: hwdata_i[15:8]};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			thermal_alarm_flag <= 1'b0;
		end else if (temp_done_i) begin // [R19]
			if (t_hi) begin
				thermal_alarm_flag <= 1'b1; // [R8]
			end else if (t_lo) begin
				thermal_alarm_flag <= 1'b0; // [R8]
			end
		end
	end

	// a match in the same cycle as a clearing access wins
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clock_alarm_flag <= 1'b0;
		end else if (t_match) begin
			clock_alarm_flag <= 1'b1; // [R9]
		end else if (clk_access) begin
			clock_alarm_flag <= 1'b0; // [R10]
		end
	end

	always_comb begin
		case (cfg.alarm_sel) // [R7]
			TCAC_ALM_THERM:  alarm_active = thermal_alarm_flag;
			TCAC_ALM_TIME:   alarm_active = clock_alarm_flag;
			TCAC_ALM_EITHER: alarm_active = thermal_alarm_flag || clock_alarm_flag; // [R17]
			default:         alarm_active = 1'b0;
		endcase
	end

	// open drain: the pin is pulled low only while its level should be low
	assign alarm_level       = alarm_active ? cfg.alarm_pol : !cfg.alarm_pol; // [R11]
	assign alarm_output_o    = 1'b0;
	assign alarm_output_oe_o = !alarm_level;

	// ----------------------------------------------------------------
	// divided clock output
	// ----------------------------------------------------------------
	logic osc_level;
	always_comb begin
		case (cfg.osc_div)
			2'h1:    osc_level = presc[OSC_TAP1];
			2'h2:    osc_level = presc[OSC_TAP2];
			2'h3:    osc_level = presc[OSC_TAP3];
			default: osc_level = xtal_s2;
		endcase
	end
	assign divided_clock_output_o    = 1'b0;
	assign divided_clock_output_oe_o = cfg.osc_en && !osc_level; // [R12]

	// ----------------------------------------------------------------
	// interrupt status, mask and sram
	// ----------------------------------------------------------------
	logic [EV_W-1:0] ev, status, mask;
	logic [31:0]     sram [SRAM_WORDS];
	logic [7:0]      sram_rd;

	assign ev[EV_THERM] = temp_done_i && t_hi && !thermal_alarm_flag;
	assign ev[EV_CLOCK] = t_match;
	assign ev[EV_DONE]  = temp_done_i;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status <= '0;
			mask   <= '0;
		end else begin
			status <= (status & ~(wr_stat ? hwdata_i[EV_W-1:0] : '0)) | ev;
			if (wr_mask) begin
				mask <= hwdata_i[EV_W-1:0];
			end
		end
	end
	assign irq_o = |(status & mask);

	// the sram feeds nothing but the read path
	generate
		for (genvar g = 0; g < SRAM_WORDS; g++) begin : g_sram
			always_ff @(posedge clk_sys_i or negedge rstn_i) begin
				if (!rstn_i) begin
					sram[g] <= 32'h0000_0000;
				end else if (dp_wr && (dp_idx == IDX_SRAM + 8'(g))) begin
					sram[g] <= hwdata_i; // [R14]
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign sram_rd = idx - IDX_SRAM;
	always_comb begin
		case (idx)
			IDX_TEMP:   rd_mux = {16'h0000, temp, 7'h00};
			IDX_HIGH:   rd_mux = {16'h0000, high_lim, 7'h00};
			IDX_LOW:    rd_mux = {16'h0000, low_lim, 7'h00};
			IDX_CFG:    rd_mux = {22'h0, busy, clock_alarm_flag, thermal_alarm_flag, cfg};
			IDX_CLK_LO: rd_mux = {tm.wday, 1'b0, tm.mode12, tm.hour, tm.min, halt, tm.sec[6:0]};
			IDX_CLK_HI: rd_mux = {8'h00, tm.year, tm.month, tm.date};
			IDX_ALARM:  rd_mux = {alm.wday, 2'h0, alm.hour, alm.min, 8'h00};
			IDX_STAT:   rd_mux = {29'h0, status};
			IDX_MASK:   rd_mux = {29'h0, mask};
			default:    rd_mux = (sram_rd < 8'(SRAM_WORDS)) ? sram[sram_rd[2:0]] : 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (acc && !hwrite_i) begin
			hrdata_o <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	alarm_none_quiet_a: assert property ((cfg.alarm_sel == TCAC_ALM_NONE) |-> (alarm_output_oe_o == cfg.alarm_pol)) // [R7]
		else $error("alarm pin active while source is none");
	therm_set_a: assert property ((temp_done_i && t_hi) |=> thermal_alarm_flag) // [R8]
		else $error("thermal flag not set at high limit");
	therm_clear_a: assert property ((temp_done_i && !t_hi && t_lo) |=> !thermal_alarm_flag) // [R8]
		else $error("thermal flag not cleared at low limit");
	clock_match_a: assert property (t_match |=> clock_alarm_flag ##0 status[EV_CLOCK]) // [R9]
		else $error("clock alarm match not flagged");
	clock_clear_a: assert property ((clk_access && !t_match) |=> !clock_alarm_flag) // [R10]
		else $error("clock flag survived clock register access");
	halt_defer_a: assert property ((wr_lo && acc) |=> $stable(halt)) // [R18]
		else $error("halt changed before bus went idle");
	temp_hold_a: assert property (!temp_done_i |=> $stable(temp)) // [R5]
		else $error("temperature changed without a done pulse");
	conv_auto_a: assert property ((init_done && !busy && !cfg.one_shot) |=> busy) // [R4]
		else $error("continuous conversion did not start");
	date_roll_a: assert property ((tick && c_month && !wr_lo && !wr_hi) |=> (tm.date == 8'h01)) // [R2]
		else $error("date did not roll over at month end");
endmodule

// ### shared/tcac_pkg.sv
package tcac_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_TEMP   = 8'hAA;
	localparam logic [7:0] IDX_HIGH   = 8'hA1;
	localparam logic [7:0] IDX_LOW    = 8'hA2;
	localparam logic [7:0] IDX_CFG    = 8'hAC;
	localparam logic [7:0] IDX_START  = 8'hEE;
	localparam logic [7:0] IDX_CLK_LO = 8'hC0;
	localparam logic [7:0] IDX_CLK_HI = 8'hC1;
	localparam logic [7:0] IDX_ALARM  = 8'hC7;
	localparam logic [7:0] IDX_STAT   = 8'h30;
	localparam logic [7:0] IDX_MASK   = 8'h31;
	localparam logic [7:0] IDX_SRAM   = 8'h20;
	localparam int         SRAM_WORDS = 8;
	localparam int         IDX_LSB    = 2;
	localparam int         ADDR_W     = 10;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TCAC_ALM_NONE, TCAC_ALM_THERM, TCAC_ALM_TIME, TCAC_ALM_EITHER} tcac_alm_sel_t;
	typedef struct packed {
		logic          osc_en;
		logic [1:0]    osc_div;
		logic          alarm_pol;
		tcac_alm_sel_t alarm_sel;
		logic          one_shot;
	} tcac_cfg_t;
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] wday;
		logic       mode12;
		logic [5:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} tcac_time_t;
	typedef struct packed {
		logic [7:0] wday;
		logic [5:0] hour;
		logic [7:0] min;
	} tcac_alarm_t;
	// ----------------------------------------------------------------
	// reset values and constants
	// ----------------------------------------------------------------
	localparam tcac_cfg_t   CFG_RST   = '{osc_en: 1'b1, osc_div: 2'h0, alarm_pol: 1'b0,
	                                      alarm_sel: TCAC_ALM_NONE, one_shot: 1'b0};
	localparam tcac_time_t  TIME_RST  = '{year: 8'h00, month: 8'h01, date: 8'h01, wday: 8'h01,
	                                      mode12: 1'b1, hour: 6'h12, min: 8'h00, sec: 8'h00};
	localparam tcac_alarm_t ALARM_RST = '{wday: 8'h01, hour: 6'h12, min: 8'h00};
	localparam logic [8:0]  HIGH_RST  = 9'h096;
	localparam logic [8:0]  LOW_RST   = 9'h08C;
	localparam int          TEMP_PAD  = 7;
	localparam int          HALT_BIT  = 7;
	localparam int          PM_BIT    = 5;
	localparam int          OSC_TAP1  = 2;
	localparam int          OSC_TAP2  = 9;
	localparam int          OSC_TAP3  = 14;
	localparam int          EV_THERM  = 0;
	localparam int          EV_CLOCK  = 1;
	localparam int          EV_DONE   = 2;
	localparam int          EV_W      = 3;
	localparam int          XTAL_HZ   = 32768;
endpackage

// ### tb/tcac_sensor_model.sv
`timescale 1ns/1ns
// ------
// temperature source: one result per start, LAT cycles later
// ------
module tcac_sensor_model #(
	parameter int LAT = 20
) (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	// sensor link
	input  wire logic       conv_start_i,
	input  wire logic [8:0] value_i,
	output logic            temp_done_o,
	output logic [8:0]      temp_result_o,
	output int              starts_o
);
	int         cnt;
	logic [8:0] res;
	// lines carry junk outside the done cycle so a stale sample is caught
	assign temp_result_o = temp_done_o ? res : ~res;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt         <= 0;
			res         <= 9'h000;
			starts_o    <= 0;
			temp_done_o <= 1'b0;
		end else begin
			temp_done_o <= 1'b0;
			if (cnt == 1) begin
				temp_done_o <= 1'b1;
				res         <= value_i;
			end
			if (cnt != 0)
				cnt <= cnt - 1;
			else if (conv_start_i) begin
				cnt      <= LAT;
				starts_o <= starts_o + 1;
			end
		end
	end
endmodule

// ### tb/tb_thermometer_clock_alarm_core.sv
`timescale 1ns/1ns
module tb_thermometer_clock_alarm_core;
	import tcac_pkg::*;
	logic              clk_sys_i, rstn_i, xtal, nvm, hsel, hwrite, done, start;
	logic              irq, aoe, doe, one_shot, hrdy, seen;
	logic [ADDR_W-1:0] haddr;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic [31:0]       hwdata, hrdata, rd;
	logic [8:0]        value, result;
	int                starts, checks, bad_count;
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		xtal = 1'b0;
		forever #80 xtal = ~xtal;
	end
	tcac_core #(.XTAL_DIV(4)) u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .crystal_input_i(xtal),
		.temp_done_i(done), .temp_result_i(result), .conv_start_o(start), .nvm_one_shot_i(nvm),
		.cfg_one_shot_o(one_shot), .alarm_output_o(), .alarm_output_oe_o(aoe),
		.divided_clock_output_o(), .divided_clock_output_oe_o(doe), .irq_o(irq));
	tcac_sensor_model u_sensor (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .conv_start_i(start),
		.value_i(value), .temp_done_o(done), .temp_result_o(result), .starts_o(starts));
	// ------
	// bus access and checking
	// ------
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk_sys_i);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {idx, 2'h0};
		hwrite <= w;
		do @(posedge clk_sys_i); while (hrdy !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys_i); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// two done pulses so the flags have seen a whole new result
	task automatic conv();
		repeat (2) @(posedge done);
		repeat (2) @(posedge clk_sys_i);
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		complete_run();
	end
	// ------
	// tests
	// ------
	initial begin
		rstn_i = 1'b0;
		nvm    = 1'b0;
		hsel   = 1'b0;
		haddr  = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = HSIZE_WORD;
		hwdata = 32'h0;
		value  = 9'h032;
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		bus(1'b0, IDX_CFG, 32'h0);
		chk(rd & 32'h7F, 32'h40);
		bus(1'b0, IDX_HIGH, 32'h0);
		chk(rd, 32'h4B00);
		bus(1'b0, IDX_LOW, 32'h0);
		chk(rd, 32'h4600);
		bus(1'b0, IDX_CLK_LO, 32'h0);
		chk(32'(rd[22]), 32'h1);
		repeat (60) @(posedge clk_sys_i);
		chk(32'(starts >= 2), 32'h1);
		$display("test reset done");
		bus(1'b1, IDX_MASK, 32'h1);
		value <= 9'h096;
		conv();
		chk(32'(irq), 32'h1);
		bus(1'b0, IDX_TEMP, 32'h0);
		chk(rd, 32'h4B00);
		value <= 9'h08D;
		conv();
		bus(1'b0, IDX_CFG, 32'h0);
		chk(32'(rd[7]), 32'h1);
		// cfg layout: osc_en 6, osc_div 5:4, alarm_pol 3, alarm_sel 2:1, one_shot 0
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, IDX_CFG, 32'h40 | 32'(s << 1));
			repeat (2) @(negedge clk_sys_i);
			chk(32'(aoe), 32'(s[0]));
		end
		bus(1'b1, IDX_CFG, 32'h4A);
		repeat (2) @(negedge clk_sys_i);
		chk(32'(aoe), 32'h0);
		bus(1'b1, IDX_STAT, 32'h1);
		repeat (2) @(negedge clk_sys_i);
		chk(32'(irq), 32'h0);
		value <= 9'h1FF;
		conv();
		bus(1'b0, IDX_CFG, 32'h0);
		chk(32'(rd[7]), 32'h0);
		bus(1'b0, IDX_TEMP, 32'h0);
		chk(rd, 32'hFF80);
		$display("test thermal done");
		bus(1'b1, IDX_CFG, 32'h0);
		seen = 1'b0;
		repeat (100) @(negedge clk_sys_i) seen |= doe;
		chk(32'(seen), 32'h0);
		bus(1'b1, IDX_CFG, 32'h40);
		repeat (100) @(negedge clk_sys_i) seen |= doe;
		chk(32'(seen), 32'h1);
		for (int i = 0; i < SRAM_WORDS; i++)
			bus(1'b1, IDX_SRAM + 8'(i), 32'hA5C3_0000 + 32'(i));
		for (int i = 0; i < SRAM_WORDS; i++) begin
			bus(1'b0, IDX_SRAM + 8'(i), 32'h0);
			chk(rd, 32'hA5C3_0000 + 32'(i));
		end
		bus(1'b0, IDX_TEMP, 32'h0);
		chk(rd, 32'hFF80);
		bus(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		$display("test sram done");
		bus(1'b1, IDX_CFG, 32'h46);
		bus(1'b1, IDX_ALARM, 32'h0112_0100);
		bus(1'b1, IDX_CLK_LO, 32'h0152_0059);
		rd = '0;
		for (int i = 0; i < 100 && rd[8] !== 1'b1; i++)
			bus(1'b0, IDX_CFG, 32'h0);
		chk(32'(rd[8]), 32'h1);
		chk(32'(aoe), 32'h1);
		bus(1'b0, IDX_CLK_LO, 32'h0);
		chk(32'(rd[31:8]), 32'h0001_5201);
		bus(1'b0, IDX_CFG, 32'h0);
		chk(32'(rd[8]), 32'h0);
		chk(32'(aoe), 32'h0);
		$display("test clock alarm done");
		// leap february 29th rolls into march 1st
		bus(1'b1, IDX_CLK_HI, 32'h0000_0229);
		bus(1'b1, IDX_CLK_LO, 32'h0223_5959);
		repeat (100) @(posedge clk_sys_i);
		bus(1'b0, IDX_CLK_HI, 32'h0);
		chk(rd, 32'h0000_0301);
		bus(1'b0, IDX_CLK_LO, 32'h0);
		chk(32'(rd[31:8]), 32'h0003_0000);
		// a tick may still land while the first halt write waits for the idle
		// cycle, so the time is loaded again once the oscillator is stopped
		bus(1'b1, IDX_CLK_LO, 32'h0152_0080);
		bus(1'b1, IDX_CLK_LO, 32'h0152_0080);
		repeat (300) @(posedge clk_sys_i);
		bus(1'b0, IDX_CLK_LO, 32'h0);
		chk(32'({rd[15:8], rd[6:0]}), 32'h0);
		bus(1'b1, IDX_CLK_LO, 32'h0152_0000);
		repeat (200) @(posedge clk_sys_i);
		bus(1'b0, IDX_CLK_LO, 32'h0);
		chk(32'(rd[6:0] != 7'h00), 32'h1);
		$display("test calendar done");
		nvm    <= 1'b1;
		rstn_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (200) @(posedge clk_sys_i);
		chk(32'(one_shot), 32'h1);
		chk(32'(starts), 32'h0);
		bus(1'b1, IDX_START, 32'h1);
		repeat (50) @(posedge clk_sys_i);
		chk(32'(starts), 32'h1);
		$display("test one shot done");
		complete_run();
	end
endmodule
